// ===== core/fls_lock.sv
// Flash lock, security, option and calibration bit controller
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
module fls_lock #(
    parameter logic [fls_pkg::FLS_CNT_W-1:0] P_ERASE_CYC =
        fls_pkg::FLS_CNT_W'(fls_pkg::FLS_ERASE_CYC),
    parameter logic [fls_pkg::FLS_CNT_W-1:0] P_BOOT_CYC =
        fls_pkg::FLS_CNT_W'(fls_pkg::FLS_BOOT_CYC)
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_nv_load,
    input wire fls_pkg::fls_nv_t i_nv_image,
    input wire fls_pkg::fls_ext_t i_ext,
    output fls_pkg::fls_resp_t o_ext_resp,
    output fls_pkg::fls_op_t o_flash_op,
    input wire logic i_flash_done,
    input wire logic i_erase_pin,
    input wire logic i_test_mode_pin,
    input wire logic i_boot_select_pin_0,
    input wire logic i_boot_select_pin_1,
    input wire logic i_boot_select_pin_2,
    output logic o_security,
    output logic o_bod_en,
    output logic o_bod_rst_en,
    output logic [fls_pkg::FLS_CAL_W-1:0] o_calib,
    output logic o_fast_prog_mode,
    output logic o_boot_restore,
    output logic o_irq
);
    import fls_pkg::*;

    fls_state_t state;
    fls_nv_t nv;
    logic [FLS_ST_W-1:0] status;
    logic [FLS_ST_W-1:0] mode;
    logic erase_meta, erase_sync;
    logic [FLS_CNT_W-1:0] erase_cnt;
    logic erase_fire, pin_pend;
    logic [FLS_CNT_W-1:0] boot_cnt;
    // Request arbitration results
    logic sw_cmd, req_valid, req_fast, req_sw;
    logic [3:0] req_cmd;
    logic [FLS_PAGE_W-1:0] req_page;
    logic req_locked, req_busy, req_denied, req_lockerr, req_go;
    logic [FLS_ST_W-1:0] events;

    // ----------------------------------------------------------------
    // Erase pin qualification
    // ----------------------------------------------------------------
    // Two-stage synchroniser; only the second stage feeds the filter
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            erase_meta <= 1'b0;
            erase_sync <= 1'b0;
        end else begin
            erase_meta <= i_erase_pin; // RQ17
            erase_sync <= erase_meta;
        end
    end

    // Duration filter: short glitches never reach the lock bits
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            erase_cnt <= '0;
            erase_fire <= 1'b0;
        end else begin
            erase_fire <= 1'b0;
            if (!erase_sync) begin
                erase_cnt <= '0; // RQ17
            end else if (erase_cnt != P_ERASE_CYC) begin
                erase_cnt <= erase_cnt + 1'b1;
                erase_fire <= (erase_cnt == P_ERASE_CYC - 1'b1); // RQ9
            end
        end
    end

    // ----------------------------------------------------------------
    // Request selection
    // ----------------------------------------------------------------
    // Software command wins over an external port in the same cycle
    always_comb begin
        sw_cmd = i_wr && (i_addr == FLS_OFS_CMD);
        req_sw = sw_cmd;
        req_valid = sw_cmd || i_ext.valid;
        req_fast = !sw_cmd && i_ext.from_fast;
        req_cmd = sw_cmd ? i_wdata[FLS_CMD_LSB +: 4] : i_ext.cmd;
        req_page = sw_cmd ? i_wdata[FLS_ARG_LSB +: FLS_PAGE_W] : i_ext.page;
        req_locked = nv.lock[req_page[FLS_REGION_LSB +: 3]]; // RQ3
        req_busy = (state != FLS_S_IDLE) || pin_pend || erase_fire;
        req_denied = 1'b0;
        if (!req_sw) begin
            if (nv.security) begin
                req_denied = 1'b1; // RQ6
            end else if (req_fast) begin
                req_denied = !o_fast_prog_mode || (req_cmd > FLS_C_SECURE); // RQ15
            end else begin
                req_denied = req_cmd > FLS_C_PERASE;
            end
        end
        if (req_cmd > FLS_C_GPCLR) begin
            req_denied = 1'b1;
        end
        req_lockerr = 1'b0;
        unique case (req_cmd)
            FLS_C_PROG, FLS_C_PERASE: req_lockerr = req_locked; // RQ1
            FLS_C_FULL: req_lockerr = |nv.lock;
            default: req_lockerr = 1'b0;
        endcase
        req_go = req_valid && !req_busy && !req_denied && !req_lockerr;
    end

    // ----------------------------------------------------------------
    // Sequencer and flash operation port
    // ----------------------------------------------------------------
    // Pin erase waits for any running page operation to finish
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= FLS_S_IDLE;
            o_flash_op <= '0;
            pin_pend <= 1'b0;
        end else begin
            o_flash_op.valid <= 1'b0;
            if (erase_fire) begin
                pin_pend <= 1'b1;
            end
            unique case (state)
                FLS_S_IDLE: begin
                    if (pin_pend || erase_fire) begin
                        pin_pend <= 1'b0;
                        o_flash_op <= '{valid: 1'b1, kind: FLS_K_FULL, page: '0}; // RQ8
                        state <= FLS_S_PIN;
                    end else if (req_go && req_cmd <= FLS_C_FULL) begin
                        o_flash_op <= '{valid: 1'b1, kind: fls_kind_t'(req_cmd[1:0]),
                                        page: req_page};
                        state <= FLS_S_OP;
                    end
                end
                FLS_S_OP: begin
                    if (i_flash_done) begin
                        state <= FLS_S_IDLE;
                    end
                end
                FLS_S_PIN: begin
                    if (i_flash_done) begin
                        state <= FLS_S_IDLE;
                    end
                end
                default: state <= FLS_S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Non-volatile bits
    // ----------------------------------------------------------------
    // Image load restores the cells' content after power-up
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            nv <= FLS_NV_RST;
        end else if (i_nv_load) begin
            nv <= i_nv_image; // RQ10
        end else begin
            if (req_go) begin
                unique case (req_cmd)
                    FLS_C_LOCK: nv.lock[req_page[FLS_REGION_LSB +: 3]] <= 1'b1; // RQ4
                    FLS_C_UNLOCK: nv.lock[req_page[FLS_REGION_LSB +: 3]] <= 1'b0; // RQ4
                    FLS_C_SECURE: nv.security <= 1'b1; // RQ7
                    FLS_C_GPSET: nv.gpnvm[req_page[0]] <= 1'b1; // RQ10
                    FLS_C_GPCLR: nv.gpnvm[req_page[0]] <= 1'b0; // RQ10
                    default: nv.security <= nv.security;
                endcase
            end
            if (erase_fire) begin
                nv.lock <= '0; // RQ5
                nv.gpnvm <= '0; // RQ11 RQ12
            end
            // Security only drops once the pin-driven full erase is done
            if (state == FLS_S_PIN && i_flash_done) begin
                nv.security <= 1'b0; // RQ8
            end
        end
    end

    // Outputs decoded from the stored bits; calibration only from image
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_security <= 1'b0;
            o_bod_en <= 1'b0;
            o_bod_rst_en <= 1'b0;
            o_calib <= '0;
        end else begin
            o_security <= nv.security;
            o_bod_en <= nv.gpnvm[0]; // RQ11
            o_bod_rst_en <= nv.gpnvm[1]; // RQ12
            o_calib <= nv.calib; // RQ13
        end
    end

    // ----------------------------------------------------------------
    // Pin straps for fast programming and boot recovery
    // ----------------------------------------------------------------
    // Recovery request holds until a reset, as a power cycle must follow
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_fast_prog_mode <= 1'b0;
            boot_cnt <= '0;
            o_boot_restore <= 1'b0;
        end else begin
            o_fast_prog_mode <= i_test_mode_pin && i_boot_select_pin_0 &&
                                i_boot_select_pin_1 && !i_boot_select_pin_2; // RQ14
            if (!(i_test_mode_pin && i_boot_select_pin_0 && i_boot_select_pin_1 &&
                  i_boot_select_pin_2)) begin
                boot_cnt <= '0;
            end else if (boot_cnt != P_BOOT_CYC) begin
                boot_cnt <= boot_cnt + 1'b1;
                if (boot_cnt == P_BOOT_CYC - 1'b1) begin
                    o_boot_restore <= 1'b1; // RQ16
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // External port answer
    // ----------------------------------------------------------------
    // One answer per external request, taken or refused
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ext_resp <= '0;
        end else begin
            o_ext_resp.valid <= i_ext.valid;
            o_ext_resp.refused <= i_ext.valid && (sw_cmd || !req_go); // RQ6
        end
    end

    // ----------------------------------------------------------------
    // Status, mode, interrupt and read port
    // ----------------------------------------------------------------
    always_comb begin
        events = '0;
        events[FLS_ST_LOCKERR] = req_valid && !req_busy && !req_denied && req_lockerr;
        events[FLS_ST_DONE] = (state == FLS_S_OP) && i_flash_done;
        events[FLS_ST_REFUSED] = req_valid && (req_busy || req_denied);
        events[FLS_ST_PINERASE] = (state == FLS_S_PIN) && i_flash_done;
    end

    // Sticky status; a new event beats a same-cycle write-one clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            status <= '0;
        end else if (i_wr && i_addr == FLS_OFS_STATUS) begin
            status <= (status & ~i_wdata[FLS_ST_W-1:0]) | events; // RQ1
        end else begin
            status <= status | events; // RQ1
        end
    end

    // Mode register doubles as the interrupt enable mask
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode <= FLS_MODE_RST;
        end else if (i_wr && i_addr == FLS_OFS_MODE) begin
            mode <= i_wdata[FLS_ST_W-1:0];
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(status & mode); // RQ2
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= '0;
            if (i_rd) begin
                unique case (i_addr)
                    FLS_OFS_MODE: o_rdata[FLS_ST_W-1:0] <= mode;
                    FLS_OFS_STATUS: o_rdata[FLS_ST_W-1:0] <= status;
                    FLS_OFS_NV: begin
                        o_rdata[FLS_REGIONS-1:0] <= nv.lock;
                        o_rdata[FLS_NV_GP_LSB +: FLS_GP_W] <= nv.gpnvm;
                        o_rdata[FLS_NV_SEC] <= nv.security;
                        o_rdata[FLS_NV_CAL_LSB +: FLS_CAL_W] <= nv.calib;
                        o_rdata[FLS_NV_FAST] <= o_fast_prog_mode;
                        o_rdata[FLS_NV_BOOT] <= o_boot_restore;
                    end
                    default: o_rdata <= '0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_lock_abort;
        @(posedge i_clk) disable iff (i_rst)
        (req_valid && !req_busy && !req_denied && req_lockerr)
            |=> !o_flash_op.valid && status[FLS_ST_LOCKERR];
    endproperty
    a_lock_abort: assert property (p_lock_abort) // RQ1
        else $error("locked command not aborted");

    property p_irq_gate;
        @(posedge i_clk) disable iff (i_rst)
        (status == 4'h1 && !mode[FLS_ST_LOCKERR]) |=> !o_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) // RQ2
        else $error("lock error irq without enable");

    property p_irq_raise;
        @(posedge i_clk) disable iff (i_rst)
        (events[FLS_ST_LOCKERR] && mode[FLS_ST_LOCKERR] && !(i_wr && i_addr != FLS_OFS_CMD))
            |-> ##2 o_irq;
    endproperty
    a_irq_raise: assert property (p_irq_raise) // RQ2
        else $error("enabled lock error gave no irq");

    property p_lock_set;
        @(posedge i_clk) disable iff (i_rst)
        (req_go && req_cmd == FLS_C_LOCK && !erase_fire && !i_nv_load)
            |=> nv.lock[$past(req_page[FLS_REGION_LSB +: 3])];
    endproperty
    a_lock_set: assert property (p_lock_set) // RQ4
        else $error("set-lock did not set region");

    property p_pin_clear;
        @(posedge i_clk) disable iff (i_rst)
        (erase_fire && !i_nv_load) |=> nv.lock == '0 ##1 !o_bod_en && !o_bod_rst_en;
    endproperty
    a_pin_clear: assert property (p_pin_clear) // RQ5 RQ11 RQ12
        else $error("erase pin left bits set");

    property p_sec_refuse;
        @(posedge i_clk) disable iff (i_rst)
        (i_ext.valid && nv.security) |=> o_ext_resp.valid && o_ext_resp.refused;
    endproperty
    a_sec_refuse: assert property (p_sec_refuse) // RQ6
        else $error("secured access not refused");

    property p_sec_hold;
        @(posedge i_clk) disable iff (i_rst)
        (nv.security && !(state == FLS_S_PIN && i_flash_done) && !i_nv_load) |=> nv.security;
    endproperty
    a_sec_hold: assert property (p_sec_hold) // RQ7 RQ8
        else $error("security cleared without pin erase");

    property p_calib_hold;
        @(posedge i_clk) disable iff (i_rst)
        !i_nv_load |=> $stable(nv.calib);
    endproperty
    a_calib_hold: assert property (p_calib_hold) // RQ13
        else $error("calibration bits changed");

    property p_fast_mode;
        @(posedge i_clk) disable iff (i_rst)
        (i_test_mode_pin && i_boot_select_pin_0 && i_boot_select_pin_1 && !i_boot_select_pin_2)
            |=> o_fast_prog_mode;
    endproperty
    a_fast_mode: assert property (p_fast_mode) // RQ14
        else $error("fast programming mode not entered");

    property p_pin_filter;
        @(posedge i_clk) disable iff (i_rst)
        erase_fire |-> $past(erase_sync) && erase_cnt == P_ERASE_CYC;
    endproperty
    a_pin_filter: assert property (p_pin_filter) // RQ17
        else $error("erase acted before qualification");

    c_lock_err: cover property (@(posedge i_clk) disable iff (i_rst) events[FLS_ST_LOCKERR]);
    c_pin_erase: cover property (@(posedge i_clk) disable iff (i_rst)
        events[FLS_ST_PINERASE] && nv.security);
    c_fast_req: cover property (@(posedge i_clk) disable iff (i_rst)
        req_go && req_fast);
    c_boot: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_boot_restore));
endmodule : fls_lock

// ===== core/fls_pkg.sv
// Package: constants, types and timing for the flash lock and security bit block
// Behaviour
// [RQ1] Locked-region erase or program aborts, flags error
// [RQ2] Lock error interrupts only when mode enable set
// [RQ3] Eight lock bits, 32 pages of 64 bytes
// [RQ4] Set-lock sets, clear-lock clears the region bit
// [RQ5] Erase pin clears every lock bit
// [RQ6] Security set refuses debug and fast-port access
// [RQ7] Security set only by command, never cleared by software
// [RQ8] Security clears after erase pin and full erase
// [RQ9] Erase pin held longer than 50 ms
// [RQ10] Two option bits, set or cleared by command
// [RQ11] Option bit 0 enables brownout detector; erase clears
// [RQ12] Option bit 1 enables brownout reset; erase clears
// [RQ13] Eight calibration bits, unchangeable, erase leaves them
// [RQ14] Test and boot pins 0,1 high, 2 low: fast mode
// [RQ15] Fast port takes read, program, erase, lock, protect
// [RQ16] Four pins high 10 s restores boot program
// [RQ17] Erase pin synchronised and qualified by duration
package fls_pkg;
    // ----------------------------------------------------------------
    // Geometry
    // ----------------------------------------------------------------
    localparam int FLS_REGIONS = 8;
    localparam int FLS_PAGES_PER_REGION = 32;
    localparam int FLS_PAGE_BYTES = 64;
    localparam int FLS_PAGE_W = 8;
    localparam int FLS_REGION_LSB = 5;
    localparam int FLS_CAL_W = 8;
    localparam int FLS_GP_W = 2;
    localparam int FLS_CNT_W = 31;
    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] FLS_OFS_CMD = 8'h00;
    localparam logic [7:0] FLS_OFS_MODE = 8'h04;
    localparam logic [7:0] FLS_OFS_STATUS = 8'h08;
    localparam logic [7:0] FLS_OFS_NV = 8'h0c;
    localparam int FLS_CMD_LSB = 0;
    localparam int FLS_ARG_LSB = 8;
    localparam int FLS_ST_W = 4;
    localparam int FLS_ST_LOCKERR = 0;
    localparam int FLS_ST_DONE = 1;
    localparam int FLS_ST_REFUSED = 2;
    localparam int FLS_ST_PINERASE = 3;
    localparam logic [FLS_ST_W-1:0] FLS_MODE_RST = 4'h0;
    localparam int FLS_NV_GP_LSB = 8;
    localparam int FLS_NV_SEC = 10;
    localparam int FLS_NV_CAL_LSB = 16;
    localparam int FLS_NV_FAST = 24;
    localparam int FLS_NV_BOOT = 25;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam longint FLS_CLK_HZ = 125_000_000;
    localparam longint FLS_ERASE_MIN_MS = 50;
    localparam longint FLS_BOOT_HOLD_S = 10;
    localparam longint FLS_ERASE_CYC = (FLS_ERASE_MIN_MS * FLS_CLK_HZ + 999) / 1000;
    localparam longint FLS_BOOT_CYC = FLS_BOOT_HOLD_S * FLS_CLK_HZ;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        FLS_C_READ = 4'h0, FLS_C_PROG = 4'h1, FLS_C_PERASE = 4'h2, FLS_C_FULL = 4'h3,
        FLS_C_LOCK = 4'h4, FLS_C_UNLOCK = 4'h5, FLS_C_SECURE = 4'h6,
        FLS_C_GPSET = 4'h7, FLS_C_GPCLR = 4'h8
    } fls_cmd_t;
    typedef enum logic [1:0] {
        FLS_K_READ = 2'h0, FLS_K_PROG = 2'h1, FLS_K_PERASE = 2'h2, FLS_K_FULL = 2'h3
    } fls_kind_t;
    typedef enum logic [2:0] {
        FLS_S_IDLE = 3'b001, FLS_S_OP = 3'b010, FLS_S_PIN = 3'b100
    } fls_state_t;
    typedef struct packed {
        logic valid;
        fls_kind_t kind;
        logic [FLS_PAGE_W-1:0] page;
    } fls_op_t;
    typedef struct packed {
        logic valid;
        logic from_fast;
        logic [3:0] cmd;
        logic [FLS_PAGE_W-1:0] page;
    } fls_ext_t;
    typedef struct packed {
        logic valid;
        logic refused;
    } fls_resp_t;
    typedef struct packed {
        logic [FLS_REGIONS-1:0] lock;
        logic [FLS_GP_W-1:0] gpnvm;
        logic security;
        logic [FLS_CAL_W-1:0] calib;
    } fls_nv_t;
    localparam fls_nv_t FLS_NV_RST = '0;
endpackage : fls_pkg

// ===== tb/fls_far.sv
// Far-side model: flash array completion and the board's erase pin
`timescale 1ns/1ns
module fls_far (
    input wire logic i_clk,
    input wire fls_pkg::fls_op_t i_op,
    input wire logic i_slow,
    output logic o_done,
    output logic o_erase_pin,
    output fls_pkg::fls_op_t o_last,
    output int o_ops
);
    import fls_pkg::*;
    initial begin
        {o_done, o_erase_pin} = 2'b00;
        o_last = '0;
        o_ops = 0;
    end
    // Array finishes each operation after a short or a long busy time
    always @(posedge i_clk) begin
        if (i_op.valid === 1'b1) begin
            o_last <= i_op;
            o_ops <= o_ops + 1;
            repeat (i_slow ? 20 : 2) @(posedge i_clk);
            o_done <= 1'b1;
            @(posedge i_clk);
            o_done <= 1'b0;
        end
    end
    // Erase pin held for n cycles; short holds probe the qualifier
    task automatic press_erase(input int n);
        @(posedge i_clk);
        o_erase_pin <= 1'b1;
        repeat (n) @(posedge i_clk);
        o_erase_pin <= 1'b0;
    endtask : press_erase
endmodule : fls_far

// ===== tb/tb_fls_lock.sv
// Self-checking bench for the flash lock and security bit block
`timescale 1ns/1ns
module tb_fls_lock;
    import fls_pkg::*;
    logic i_clk, i_rst, i_wr, i_rd, i_nv_load, i_slow, done, epin, sec, bod, bodr, fast, boot, irq;
    logic tm, b0, b1, b2, m_sec, m_fast, m_boot;
    logic [7:0] i_addr, cal, pg, calib, m_lock;
    logic [1:0] m_gp;
    logic [3:0] m_st, m_mode;
    logic [31:0] i_wdata, o_rdata, rv;
    fls_nv_t i_nv_image;
    fls_ext_t i_ext;
    fls_resp_t resp;
    fls_op_t fop, last, q[$];
    int fail_count, n_tests, cyc, ops, seed;
    fls_lock #(.P_ERASE_CYC(31'd16), .P_BOOT_CYC(31'd32)) u_fls_lock (.i_clk(i_clk),
        .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_nv_load(i_nv_load), .i_nv_image(i_nv_image), .i_ext(i_ext),
        .o_ext_resp(resp), .o_flash_op(fop), .i_flash_done(done), .i_erase_pin(epin),
        .i_test_mode_pin(tm), .i_boot_select_pin_0(b0), .i_boot_select_pin_1(b1),
        .i_boot_select_pin_2(b2), .o_security(sec), .o_bod_en(bod), .o_bod_rst_en(bodr),
        .o_calib(calib), .o_fast_prog_mode(fast), .o_boot_restore(boot), .o_irq(irq));
    fls_far u_fls_far (.i_clk(i_clk), .i_op(fop), .i_slow(i_slow), .o_done(done),
        .o_erase_pin(epin), .o_last(last), .o_ops(ops));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    // Hang guard, well above the expected run length
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic ext(input logic f, input logic [3:0] c, input logic [7:0] p);
        @(posedge i_clk);
        i_ext <= '{1'b1, f, c, p};
        @(posedge i_clk);
        i_ext.valid <= 1'b0;
        #1 rv = {30'h0, resp};
    endtask : ext
    // Bounded wait for the array to finish, then let results settle
    task automatic wt();
        for (int k = 0; k < 80 && done !== 1'b1; k++) @(posedge i_clk) #1;
        if (done !== 1'b1) chk("done", 1, 0);
        repeat (3) @(posedge i_clk);
    endtask : wt
    task automatic chk_nv();
        rd(8'h0c);
        chk("nv", {6'h0, m_boot, m_fast, cal, 5'h0, m_sec, m_gp, m_lock}, rv);
        rd(8'h08);
        chk("status", 32'(m_st), rv);
        chk("irq", 32'((m_st & m_mode) != 0), 32'(irq));
        chk("pins", {m_sec, m_gp, cal}, {sec, bodr, bod, calib});
    endtask : chk_nv
    // One command through the register port or the fast port, model updated alongside
    task automatic run(input logic f, input logic [3:0] c, input logic [7:0] p);
        logic err;
        int n0;
        n0 = ops;
        err = (c == 4'h1 || c == 4'h2) ? m_lock[p[7:5]] : (c == 4'h3 && m_lock != 0);
        if (f) begin
            ext(1'b1, c, p);
            chk("ext_resp", 32'h2, rv);
        end else wr(8'h00, {16'h0, p, 4'h0, c});
        if (c <= 4'h3 && !err) begin
            q.push_back('{1'b1, fls_kind_t'(c[1:0]), p});
            wt();
            m_st |= 4'h2;
            chk("op", 32'(q.pop_front()), 32'(last));
        end else begin
            repeat (3) @(posedge i_clk);
            chk("no_op", n0, ops);
            m_st |= {3'h0, err};
            case (c)
                4'h4: m_lock[p[7:5]] = 1'b1;
                4'h5: m_lock[p[7:5]] = 1'b0;
                4'h6: m_sec = 1'b1;
                4'h7: m_gp[p[0]] = 1'b1;
                4'h8: m_gp[p[0]] = 1'b0;
                default: ;
            endcase
        end
        chk_nv();
    endtask : run
    task automatic tdone(input string s);
        $display("test %s finished", s);
    endtask : tdone
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    initial begin
        {i_rst, i_wr, i_rd, i_nv_load, i_slow, tm, b0, b1, b2} = 9'h100;
        {i_addr, i_wdata, cal, m_lock, m_gp, m_st, m_mode, m_sec, m_fast, m_boot} = '0;
        i_nv_image = '0;
        i_ext = '0;
        seed = 32'hf542;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        chk_nv();
        rd(8'h10);
        chk("unmapped", 0, rv);
        cal = 8'($random(seed));
        i_nv_image <= '{8'h00, 2'h0, 1'b0, cal};
        i_nv_load <= 1'b1;
        @(posedge i_clk);
        i_nv_load <= 1'b0;
        tdone("reset");
        pg = 8'($random(seed));
        run(0, 4'h4, pg);
        run(0, 4'h1, pg ^ 8'h1f);
        run(0, 4'h3, 8'h00);
        run(0, 4'h2, pg ^ 8'h20);
        wr(8'h04, 32'h1);
        m_mode = 4'h1;
        run(0, 4'h2, pg);
        wr(8'h08, 32'hf);
        m_st = 4'h0;
        i_slow <= 1'b1;
        run(0, 4'h5, pg);
        run(0, 4'h1, pg);
        for (int i = 0; i < 2; i++) run(0, 4'h7, 8'(i));
        run(0, 4'h8, 8'h01);
        tdone("lock");
        for (int i = 0; i < 16; i++) begin
            {tm, b0, b1, b2} <= 4'(i);
            repeat (3) @(posedge i_clk);
            #1 chk("fast", 32'(i == 14), 32'(fast));
        end
        {tm, b0, b1, b2} <= 4'he;
        m_fast = 1'b1;
        for (int c = 0; c < 7; c++) run(1, 4'(c), 8'($random(seed)));
        for (int f = 0; f < 2; f++) begin
            ext(1'(f), 4'h0, 8'h00);
            chk("secured_resp", 32'h3, rv);
            m_st |= 4'h4;
        end
        run(0, 4'h8, 8'h00);
        run(0, 4'h5, 8'h00);
        tdone("secure");
        run(0, 4'h4, 8'he0);
        run(0, 4'h7, 8'h00);
        u_fls_far.press_erase(8);
        repeat (30) @(posedge i_clk);
        chk_nv();
        i_slow <= 1'b0;
        fork
            u_fls_far.press_erase(40);
        join_none
        {m_lock, m_gp, m_sec} = '0;
        m_st |= 4'h8;
        wt();
        repeat (40) @(posedge i_clk);
        chk("erase_kind", 32'(FLS_K_FULL), 32'(last.kind));
        chk_nv();
        ext(1'b0, 4'h0, 8'h00);
        chk("open_resp", 32'h2, rv);
        wt();
        ext(1'b1, 4'h7, 8'h00);
        chk("fast_refuse", 32'h3, rv);
        tdone("erase");
        {tm, b0, b1, b2} <= 4'hf;
        repeat (40) @(posedge i_clk);
        #1 chk("boot", 1, 32'(boot));
        tdone("boot");
        end_of_test();
    end
endmodule : tb_fls_lock
